// [inc/status_pkg.sv]
// Shared constants for the receiver status register bank
package status_pkg;
  localparam logic [5:0] ADDR_PART_NUMBER = 6'h30;
  localparam logic [5:0] ADDR_SILICON_REV = 6'h31;
  localparam logic [5:0] ADDR_OFFSET_EST  = 6'h32;
  localparam logic [5:0] ADDR_CHECK_RES   = 6'h33;
  localparam logic [5:0] ADDR_SIG_STRENGTH = 6'h34;
  localparam logic [5:0] ADDR_RADIO_STATE = 6'h35;
  localparam logic [5:0] ADDR_PKT_STATUS  = 6'h38;
  localparam int CRC_OK_BIT   = 7;
  localparam int CS_BIT       = 6;
  localparam int SFD_BIT      = 3;
  localparam int PIN_TWO_BIT  = 2;
  localparam int PIN_ZERO_BIT = 0;
  localparam logic [4:0] ST_SLEEP    = 5'h00;
  localparam logic [4:0] ST_IDLE     = 5'h01;
  localparam logic [4:0] ST_OSCILLATOR_OFF_STATE     = 5'h02;
  localparam logic [4:0] ST_RX       = 5'h0d;
  localparam logic [4:0] ST_RX_RST   = 5'h0f;
  localparam logic [4:0] ST_OVERFLOW = 5'h11;
  localparam logic [4:0] ST_LAST_OK  = 5'h11;
  localparam logic [4:0] ST_RESERVED = 5'h10;
  localparam logic [7:0] DATA_ZERO   = 8'h00;
  localparam logic [7:0] PART_NUMBER_DEFAULT = 8'h5a; // Arbitrary value
  localparam logic [7:0] SILICON_REV_DEFAULT = 8'h3c; // Arbitrary value
  typedef enum logic [1:0] {MOD_2FSK, MOD_GFSK, MOD_OOK, MOD_4FSK} mod_format_t;
endpackage

// [rtl/receiver_status_registers.sv]
// Read-only status register bank of the packet receiver
`timescale 1ns/1ps
`default_nettype none
module receiver_status_registers
  import status_pkg::*;
(
  input  wire logic       clk_i,            // Crystal-derived clock
  input  wire logic       rst_i,            // Sync reset, active high
  input  wire logic       access_start_i,   // Pulse: serial access begins
  input  wire logic       rd_en_i,          // Pulse: read request
  input  wire logic       wr_en_i,          // Pulse: write request, ignored
  input  wire logic [5:0] addr_i,           // Register address
  input  wire logic [7:0] wr_data_i,        // Write data, ignored
  output logic      [7:0] rd_data_o,        // Registered read data
  output logic            rd_valid_o,       // Pulse: read data valid
  output logic            wake_to_idle_o,   // Pulse: force radio to idle, follows access_start_i
  input  wire logic [7:0] offset_est_i,     // Demodulator offset estimate
  input  wire logic [1:0] mod_format_i,     // Selected modulation
  input  wire logic       crc_done_i,       // Pulse: CRC compared
  input  wire logic       crc_match_i,      // CRC compare result
  input  wire logic [7:0] signal_strength_i,           // Signal strength
  input  wire logic [4:0] radio_state_i,    // Control state machine code
  input  wire logic       carrier_sense_i,  // Carrier sense level
  input  wire logic       sync_found_i,     // Pulse: sync word received
  input  wire logic       packet_end_i,     // Pulse: end of packet
  input  wire logic       packet_discard_i, // Pulse: filter discard
  input  wire logic       aux_pin_two_i,    // Pin two before inversion
  input  wire logic       aux_pin_zero_i    // Pin zero before inversion
);
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;
  logic [4:0] state_prev_r;
  logic [4:0] state_prev_nxt;
  logic       pin_two_s;
  logic       pin_zero_s;
  logic       crc_ok;
  logic       frame_start_flag;
  logic       crc_set;
  logic       crc_clr;
  logic       sfd_clr;
  logic       rx_enter;
  logic       idle_enter;
  logic       cs_bit;
  logic [4:0] state_seen;
  logic [7:0] offset_seen;
  logic [7:0] pkt_word;

  // Pins come from another domain
  sync_bit u_sync_two (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (aux_pin_two_i),
    .q_o   (pin_two_s)
  );
  sync_bit u_sync_zero (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (aux_pin_zero_i),
    .q_o   (pin_zero_s)
  );

  // Receive entered or restarted
  // Staying in the restart code is not a fresh entry, so a restart that lingers
  // for several cycles clears the flag only in its first cycle
  assign rx_enter   = (radio_state_i == ST_RX || radio_state_i == ST_RX_RST)
                      && (state_prev_r != radio_state_i) && (state_prev_r != ST_RX_RST);
  assign idle_enter = (radio_state_i == ST_IDLE);
  assign crc_set    = crc_done_i & crc_match_i;
  assign crc_clr    = rx_enter | (crc_done_i & ~crc_match_i);

  sticky_flag u_crc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (crc_set),
    .clr_i (crc_clr),
    .q_o   (crc_ok)
  );

  assign sfd_clr = packet_end_i | packet_discard_i | (radio_state_i == ST_OVERFLOW);

  sticky_flag u_sfd (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (sync_found_i),
    .clr_i (sfd_clr),
    .q_o   (frame_start_flag)
  );

  // Masked live rather than latched: a late carrier edge cannot leak into idle
  assign cs_bit = carrier_sense_i & ~idle_enter;

  // Sleep/oscillator_off_state map to idle since any access wakes the chip; reserved codes read as given
  always_comb begin
    state_seen = radio_state_i;
    if (radio_state_i == ST_SLEEP || radio_state_i == ST_OSCILLATOR_OFF_STATE) begin
      state_seen = ST_IDLE;
    end
  end

  assign offset_seen = (mod_format_i == MOD_OOK) ? DATA_ZERO : offset_est_i;

  always_comb begin
    pkt_word               = DATA_ZERO;
    pkt_word[CRC_OK_BIT]   = crc_ok;
    pkt_word[CS_BIT]       = cs_bit;
    pkt_word[SFD_BIT]      = frame_start_flag;
    pkt_word[PIN_TWO_BIT]  = pin_two_s;
    pkt_word[PIN_ZERO_BIT] = pin_zero_s;
  end

  always_comb begin
    rd_valid_nxt   = rd_en_i;
    state_prev_nxt = radio_state_i;
    rd_data_nxt    = rd_data_r;
    if (rd_en_i) begin
      unique case (addr_i)
        ADDR_PART_NUMBER:  rd_data_nxt = PART_NUMBER_DEFAULT;
        ADDR_SILICON_REV:  rd_data_nxt = SILICON_REV_DEFAULT;
        ADDR_OFFSET_EST:   rd_data_nxt = offset_seen;
        ADDR_CHECK_RES:    rd_data_nxt = {crc_ok, 7'h00};
        ADDR_SIG_STRENGTH: rd_data_nxt = signal_strength_i;
        ADDR_RADIO_STATE:  rd_data_nxt = {3'h0, state_seen};
        ADDR_PKT_STATUS:   rd_data_nxt = pkt_word;
        default:           rd_data_nxt = DATA_ZERO;
      endcase
    end
  end

  // Write port deliberately unconnected to any state
  // Read data is held between reads so a slow host can sample late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r    <= DATA_ZERO;
      rd_valid_r   <= 1'b0;
      state_prev_r <= ST_IDLE;
    end else begin
      rd_data_r    <= rd_data_nxt;
      rd_valid_r   <= rd_valid_nxt;
      state_prev_r <= state_prev_nxt;
    end
  end

  assign rd_data_o      = rd_data_r;
  assign rd_valid_o     = rd_valid_r;
  assign wake_to_idle_o = access_start_i;

  logic unused_w;
  assign unused_w = wr_en_i ^ (^wr_data_i);

  identity_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PART_NUMBER |=> rd_data_o == PART_NUMBER_DEFAULT)
    else $error("part number read wrong");
  ook_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_OFFSET_EST && mod_format_i == MOD_OOK |=> rd_data_o == 8'h00)
    else $error("offset not zero under ook");
  offset_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_OFFSET_EST && mod_format_i != MOD_OOK
    |=> rd_data_o == $past(offset_est_i))
    else $error("offset estimate mismatch");
  crc_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS |=> rd_data_o[7] == $past(crc_ok))
    else $error("crc mirror mismatch");
  crc_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_enter && !crc_set |=> !crc_ok)
    else $error("crc not cleared on rx entry");
  signal_strength_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_SIG_STRENGTH |=> rd_data_o == $past(signal_strength_i))
    else $error("signal_strength mismatch");
  state_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_RADIO_STATE |=> rd_data_o[7:5] == 3'h0
    && rd_data_o[4:0] != ST_SLEEP && rd_data_o[4:0] != ST_OSCILLATOR_OFF_STATE)
    else $error("radio state read wrong");
  sfd_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sfd_clr && !sync_found_i |=> !frame_start_flag)
    else $error("frame start not dropped");
  sfd_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_found_i |=> frame_start_flag)
    else $error("frame start not set");
  cs_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS && idle_enter |=> !rd_data_o[6])
    else $error("carrier sense in idle");
  pin_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS |=> rd_data_o[2] == $past(pin_two_s)
    && rd_data_o[0] == $past(pin_zero_s) && rd_data_o[5:4] == 2'h0 && !rd_data_o[1])
    else $error("pin status bits wrong");
  write_inert_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en_i && !rd_en_i |=> $stable(rd_data_o))
    else $error("write changed read data");

  // Read handshake timing and unmapped reads
  read_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i |=> rd_valid_o)
    else $error("read valid missing");

  valid_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_en_i |=> !rd_valid_o)
    else $error("read valid without read");

  hold_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without read");

  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == 6'h3f |=> rd_data_o == DATA_ZERO)
    else $error("unmapped read not zero");

  // Register contents
  revision_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_SILICON_REV |=> rd_data_o == SILICON_REV_DEFAULT)
    else $error("revision read wrong");

  check_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_CHECK_RES |=> rd_data_o[6:0] == 7'h00)
    else $error("check result low bits set");

  crc_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_CHECK_RES |=> rd_data_o[7] == $past(crc_ok))
    else $error("check result bit wrong");

  crc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    crc_set |=> crc_ok)
    else $error("crc match not recorded");

  crc_fail_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    crc_done_i && !crc_match_i |=> !crc_ok)
    else $error("crc mismatch left flag set");

  state_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_RADIO_STATE && radio_state_i != ST_SLEEP
    && radio_state_i != ST_OSCILLATOR_OFF_STATE |=> rd_data_o[4:0] == $past(radio_state_i))
    else $error("state code not passed");

  wake_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_to_idle_o == access_start_i)
    else $error("wake request not following access");

  cs_live_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS && !idle_enter
    |=> rd_data_o[6] == $past(carrier_sense_i))
    else $error("carrier sense not live");

  sfd_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS |=> rd_data_o[3] == $past(frame_start_flag))
    else $error("frame start bit wrong");

  sfd_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    packet_end_i && !sync_found_i |=> !frame_start_flag)
    else $error("frame start kept past end");

  overflow_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    radio_state_i == ST_OVERFLOW && !sync_found_i |=> !frame_start_flag)
    else $error("frame start kept in overflow");

  pin_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS |=> rd_data_o[2] == $past(pin_two_s))
    else $error("pin two bit wrong");

  pin_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == ADDR_PKT_STATUS |=> rd_data_o[0] == $past(pin_zero_s))
    else $error("pin zero bit wrong");

endmodule
`default_nettype wire

// [rtl/sticky_flag.sv]
// Set/clear flag with set winning over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input  wire logic clk_i, // Clock
  input  wire logic rst_i, // Sync reset
  input  wire logic set_i, // Set pulse
  input  wire logic clr_i, // Clear pulse
  output logic      q_o    // Flag
);
  logic q_r;
  logic q_nxt;
  always_comb begin
    q_nxt = q_r;
    if (clr_i) begin
      q_nxt = 1'b0;
    end
    // An event in the clearing cycle must not be lost
    if (set_i) begin
      q_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign q_o = q_r;
endmodule
`default_nettype wire

// [rtl/sync_bit.sv]
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
  input  wire logic clk_i, // Clock
  input  wire logic rst_i, // Sync reset
  input  wire logic d_i,   // Async level
  output logic      q_o    // Synchronised level
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;
  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end
  assign q_o = q_r;
endmodule
`default_nettype wire

// [sim/host_model.sv]
// Host that issues single-byte register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_i,      // Clock
  input  wire logic [7:0] rd_data_i,  // Read data
  input  wire logic       rd_valid_i, // Read data valid
  input  wire logic       wake_i,     // Forced-idle request
  output logic            start_o,    // Access start
  output logic            rd_en_o,    // Read strobe
  output logic            wr_en_o,    // Write strobe
  output logic      [5:0] addr_o,     // Address
  output logic      [7:0] wr_data_o   // Write data
);
  initial begin
    start_o   = 1'b0;
    rd_en_o   = 1'b0;
    wr_en_o   = 1'b0;
    addr_o    = 6'h00;
    wr_data_o = 8'h00;
  end
  // A read is ok only if wake follows the strobe and read valid is high one cycle later
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    start_o <= 1'b1;
    rd_en_o <= 1'b1;
    addr_o  <= a;
    #1 ok = (wake_i === 1'b1);
    @(posedge clk_i);
    start_o <= 1'b0;
    rd_en_o <= 1'b0;
    addr_o  <= ~a;
    #1 ok = ok && (rd_valid_i === 1'b1);
    d = rd_data_i;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    start_o   <= 1'b1;
    wr_en_o   <= 1'b1;
    addr_o    <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    start_o   <= 1'b0;
    wr_en_o   <= 1'b0;
    addr_o    <= ~a;
    wr_data_o <= ~d;
    // Let the release settle before a following request raises strobes again
    #1;
  endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the status register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import status_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, start, rd_en, wr_en, rd_valid, wake;
  logic [5:0] addr;
  logic [7:0] wr_data, rd_data, off = 8'h9c, signal_strength = 8'h00;
  logic [1:0] mfmt = 2'd0;
  logic [4:0] st = ST_IDLE;
  logic crc_d = 0, crc_m = 0, cs = 0, syn = 0, pend = 0, disc = 0, p2 = 0, p0 = 0;
  int bad_count = 0, checks_done = 0;
  always #10 clk_i = ~clk_i;
  receiver_status_registers dut (.clk_i(clk_i), .rst_i(rst_i), .access_start_i(start),
    .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .wr_data_i(wr_data),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wake_to_idle_o(wake),
    .offset_est_i(off), .mod_format_i(mfmt), .crc_done_i(crc_d), .crc_match_i(crc_m),
    .signal_strength_i(signal_strength), .radio_state_i(st), .carrier_sense_i(cs), .sync_found_i(syn),
    .packet_end_i(pend), .packet_discard_i(disc), .aux_pin_two_i(p2), .aux_pin_zero_i(p0));
  host_model host (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .wake_i(wake),
    .start_o(start), .rd_en_o(rd_en), .wr_en_o(wr_en), .addr_o(addr), .wr_data_o(wr_data));
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Read one register; a missing answer ends the run
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    checks_done++;
    if (!ok || d !== exp) begin
      $display("wrong value at %0t: addr %h got %h exp %h", $time, a, d, exp);
      bad_count++;
      if (!ok) finish_test();
    end
  endtask
  task automatic pkt(input logic c, s, f, b2, b0);
    rc(ADDR_PKT_STATUS, {c, s, 2'b00, f, b2, 1'b0, b0});
  endtask
  task automatic t_ids();
    rc(ADDR_PART_NUMBER, PART_NUMBER_DEFAULT);
    host.wr(ADDR_PART_NUMBER, 8'ha5);
    rc(ADDR_PART_NUMBER, PART_NUMBER_DEFAULT);
    host.wr(ADDR_SILICON_REV, 8'h00);
    rc(ADDR_SILICON_REV, SILICON_REV_DEFAULT);
    rc(6'h3f, DATA_ZERO);
  endtask
  task automatic t_offset();
    for (int m = 0; m < 4; m++) begin
      mfmt <= 2'(m);
      tick(1);
      rc(ADDR_OFFSET_EST, (mod_format_t'(m) == MOD_OOK) ? DATA_ZERO : off);
    end
    signal_strength <= 8'hc3;
    tick(1);
    rc(ADDR_SIG_STRENGTH, 8'hc3);
  endtask
  task automatic t_state();
    for (int s = 0; s < 5'h13; s++) begin
      st <= 5'(s);
      tick(1);
      rc(ADDR_RADIO_STATE, (s == 0 || s == 2) ? 8'h01 : 8'(s));
    end
  endtask
  task automatic t_crc();
    st <= ST_IDLE;
    crc_d <= 1'b1;
    crc_m <= 1'b1;
    tick(1);
    crc_d <= 1'b0;
    tick(1);
    rc(ADDR_CHECK_RES, 8'h80);
    pkt(1, 0, 0, 0, 0);
    st <= ST_RX;
    tick(2);
    rc(ADDR_CHECK_RES, 8'h00);
  endtask
  task automatic t_flags();
    cs <= 1'b1;
    tick(1);
    pkt(0, 1, 0, 0, 0);
    st <= ST_IDLE;
    tick(2);
    pkt(0, 0, 0, 0, 0);
    for (int k = 0; k < 3; k++) begin
      syn <= 1'b1;
      tick(1);
      syn <= 1'b0;
      tick(1);
      pkt(0, 0, 1, 0, 0);
      if (k == 0) pend <= 1'b1;
      if (k == 1) disc <= 1'b1;
      if (k == 2) st <= ST_OVERFLOW;
      tick(1);
      pend <= 1'b0;
      disc <= 1'b0;
      tick(1);
      pkt(0, k == 2, 0, 0, 0);
      st <= ST_IDLE;
    end
  endtask
  task automatic t_pins();
    p2 <= 1'b1;
    tick(4);
    pkt(0, 0, 0, 1, 0);
    p2 <= 1'b0;
    p0 <= 1'b1;
    tick(4);
    pkt(0, 0, 0, 0, 1);
  endtask
  initial begin
    tick(10);
    rst_i <= 1'b0;
    tick(1);
    t_ids();
    t_offset();
    t_state();
    t_crc();
    t_flags();
    t_pins();
    tick(2);
    finish_test();
  end
endmodule
`default_nettype wire
